// File: rtl/dtc_regs.svh
// Register offsets, field positions, reset values and counts of the dual timer block.
// Assumes inclusion by bare name from the design files that need it.
`ifndef DTC_REGS_SVH
`define DTC_REGS_SVH
`define DTC_ADDR_COUNT0    8'h0D
`define DTC_ADDR_CTRL0     8'h0E
`define DTC_ADDR_COUNT1    8'h10
`define DTC_ADDR_CTRL1     8'h11
`define DTC_ADDR_IRQ0      8'h0B
`define DTC_ADDR_IRQ1      8'h1E
`define DTC_BIT_MASTER_EN  0
`define DTC_BIT_EN_CTR0    3
`define DTC_BIT_FLAG_CTR0  6
`define DTC_BIT_EN_CTR1    0
`define DTC_BIT_FLAG_CTR1  4
`define DTC_IRQ0_MASK      8'h49
`define DTC_IRQ1_MASK      8'h11
`define DTC_RST_COUNT      8'h00
`define DTC_RST_CTRL       8'h00
`define DTC_RST_IRQ        8'h00
`define DTC_RST_READ       8'h00
`define DTC_COUNT_TOP      8'hFF
`define DTC_DIV4_LAST      2'h3
`define DTC_SRC1_OVF0      2'h0
`define DTC_SRC1_SYSCLK    2'h1
`define DTC_SRC1_TBASE     2'h2
`endif

// File: rtl/dtc_pkg.sv
// Types shared by the dual timer block.
// Assumes nothing beyond a SystemVerilog compiler.
package dtc_pkg;
   typedef enum logic [1:0] {
      DTC_MODE_NONE  = 2'b00,
      DTC_MODE_EVENT = 2'b01,
      DTC_MODE_TIMER = 2'b10,
      DTC_MODE_PULSE = 2'b11
   } dtc_mode_t;
   typedef enum logic [1:0] {
      DTC_PW_IDLE = 2'b00,
      DTC_PW_WAIT = 2'b01,
      DTC_PW_MEAS = 2'b10,
      DTC_PW_DONE = 2'b11
   } dtc_pw_state_t;
   typedef struct packed {
      dtc_mode_t  mode;
      logic       src_sel;
      logic       run;
      logic       edge_sel;
      logic [2:0] zero;
   } dtc_ctrl_t;
   typedef struct packed {
      logic [7:0] count;
      logic       ovf;
      logic       pw_done;
   } dtc_cnt_stat_t;
endpackage

// File: rtl/dtc_counter.sv
// One 8-bit up counter with preload, event, timer and pulse width modes.
// Assumes a synchronous event input and a one-cycle internal tick.
`timescale 1ns/1ps
`include "dtc_regs.svh"
module dtc_counter
   import dtc_pkg::*;
(
   input  wire logic          clock_i,
   input  wire logic          arst_n_i,
   input  wire dtc_ctrl_t     ctrl_i,
   input  wire logic          tick_i,
   input  wire logic          evt_i,
   input  wire logic          load_i,
   input  wire logic [7:0]    wdata_i,
   input  wire logic          hold_i,
   output dtc_cnt_stat_t      stat_o
);
   logic [7:0]    count;
   logic [7:0]    preload;
   logic          evt_q;
   logic          ovf_q;
   logic          done_q;
   dtc_pw_state_t pw_state;
   logic          rise;
   logic          fall;
   logic          pw_start;
   logic          pw_stop;
   logic          inc;
   logic [7:0]    reload;

   assign rise     = evt_i & ~evt_q;
   assign fall     = ~evt_i & evt_q;
   assign pw_start = ctrl_i.edge_sel ? rise : fall;
   assign pw_stop  = ctrl_i.edge_sel ? fall : rise;
   assign reload   = load_i ? wdata_i : preload;

   always_comb begin
      inc = 1'b0;
      case (ctrl_i.mode)
         DTC_MODE_EVENT: inc = ctrl_i.edge_sel ? fall : rise;
         DTC_MODE_TIMER: inc = tick_i;
         DTC_MODE_PULSE: inc = (pw_state == DTC_PW_MEAS) & tick_i & ~pw_stop;
         default:        inc = 1'b0;
      endcase
      inc = inc & ctrl_i.run & ~hold_i;
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         evt_q <= 1'b0;
      end else begin
         evt_q <= evt_i;
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pw_state <= DTC_PW_IDLE;
         done_q   <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (!ctrl_i.run || ctrl_i.mode != DTC_MODE_PULSE) begin
            pw_state <= DTC_PW_IDLE;
         end else begin
            case (pw_state)
               DTC_PW_IDLE: pw_state <= DTC_PW_WAIT;
               DTC_PW_WAIT: begin
                  if (pw_start) begin
                     pw_state <= DTC_PW_MEAS;
                  end
               end
               DTC_PW_MEAS: begin
                  if (pw_stop) begin
                     pw_state <= DTC_PW_DONE;
                     done_q   <= 1'b1;
                  end
               end
               default: pw_state <= DTC_PW_DONE;
            endcase
         end
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         preload <= `DTC_RST_COUNT;
      end else if (load_i) begin
         preload <= wdata_i;
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         count <= `DTC_RST_COUNT;
         ovf_q <= 1'b0;
      end else begin
         ovf_q <= inc & (count == `DTC_COUNT_TOP);
         if (load_i && !ctrl_i.run) begin
            count <= wdata_i;
         end else if (inc) begin
            count <= (count == `DTC_COUNT_TOP) ? reload : count + 8'h01;
         end
      end
   end

   assign stat_o = '{count: count, ovf: ovf_q, pw_done: done_q};
endmodule

// File: rtl/dtc_divider_pin.sv
// Divider output stage: toggles on overflow and drives the shared pin.
// Assumes a one-cycle overflow pulse and the port data latch as a level.
`timescale 1ns/1ps
module dtc_divider_pin (
   input  wire logic clock_i,
   input  wire logic arst_n_i,
   input  wire logic ovf_i,
   input  wire logic latch_i,
   output logic      pin_o,
   output logic      pin_oe_n_o
);
   logic freq_divider_out;

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         freq_divider_out <= 1'b0;
      end else if (ovf_i) begin
         freq_divider_out <= ~freq_divider_out;
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pin_o <= 1'b0;
      end else begin
         pin_o <= ~latch_i & freq_divider_out;
      end
   end

   assign pin_oe_n_o = 1'b0;
endmodule

// File: rtl/dtc_timer_top.sv
// Dual 8-bit timer/event counter with divider output, on the CPU data bus.
// Assumes a single-cycle data bus strobe and synchronous event pins.
`timescale 1ns/1ps
`include "dtc_regs.svh"

// Notes on behaviour
// - Event and timer modes count up to FF.
// - Overflow reloads preload and sets the flag.
// - Pulse mode counts between chosen edges, clears run.
// - Finished measurement holds until run set again.
// - Pulse measurement starts on edges, not levels.
// - Counters count only while run bit set.
// - Run bit clears only by software otherwise.
// - Any overflow requests wake from halt.
// - Divider pin follows one counter, chosen at build.
// - Cleared enable bit suppresses that interrupt request.
// - Pin gives divider when latch low, else zero.
// - Divider frequency is tick over 2*(256-N).
// - Write while stopped also loads the counter.
// - Write while running updates the preload, and loads the counter too if it wraps in that cycle.
// - Reading the counter blocks its counting clock.
// - Counter one can count counter zero overflows.
// - Mode field picks event, timer or pulse.
// - Event edge bit one counts falling edges.
// - Writes go to preload, reads show count.
module dtc_timer_top
   import dtc_pkg::*;
#(
   parameter logic       OPT_CTR0_DIV4 = 1'b0,
   parameter logic [1:0] OPT_CTR1_SRC  = 2'h0,
   parameter logic       OPT_PFD_CTR1  = 1'b0
) (
   input  wire logic       clock_i,
   input  wire logic       arst_n_i,
   input  wire logic [7:0] cpu_addr_i,
   input  wire logic [7:0] cpu_wdata_i,
   input  wire logic       cpu_wr_i,
   input  wire logic       cpu_rd_i,
   output logic [7:0]      cpu_rdata_o,
   input  wire logic       rtc_tick_i,
   input  wire logic       tbase_tick_i,
   input  wire logic       event_pin0_i,
   input  wire logic       event_pin1_i,
   input  wire logic       divider_latch_i,
   output logic            irq_req_ctr0_o,
   output logic            irq_req_ctr1_o,
   output logic            wake_req_o,
   output logic            shared_divider_pin_o,
   output logic            shared_divider_pin_oe_n_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // Bus decode.

   dtc_ctrl_t     control_reg_ctr0;
   dtc_ctrl_t     timer1_control;
   logic [7:0]    irq_ctrl_first;
   logic [7:0]    irq_ctrl_second;
   logic [7:0]    next_irq_first;
   logic [7:0]    next_irq_second;
   logic [1:0]    div4_cnt;
   logic          div4_tick;
   logic          tick_ctr0;
   logic          tick_ctr1;
   logic          opt_tick_ctr1;
   dtc_cnt_stat_t stat_ctr0;
   dtc_cnt_stat_t stat_ctr1;
   logic          wr_count0;
   logic          wr_count1;
   logic          wr_ctrl0;
   logic          wr_ctrl1;
   logic          wr_irq0;
   logic          wr_irq1;
   logic          rd_count0;
   logic          rd_count1;
   logic          pfd_ovf;

   // Control bytes keep their low three bits at zero.
   function automatic dtc_ctrl_t dtc_ctrl_from_byte(input logic [7:0] b);
      dtc_ctrl_from_byte = dtc_ctrl_t'({b[7:3], 3'h0});
   endfunction

   function automatic logic dtc_hit(input logic strobe, input logic [7:0] addr, input logic [7:0] target);
      dtc_hit = strobe & (addr == target);
   endfunction

   assign wr_count0 = dtc_hit(cpu_wr_i, cpu_addr_i, `DTC_ADDR_COUNT0);
   assign wr_count1 = dtc_hit(cpu_wr_i, cpu_addr_i, `DTC_ADDR_COUNT1);
   assign wr_ctrl0  = dtc_hit(cpu_wr_i, cpu_addr_i, `DTC_ADDR_CTRL0);
   assign wr_ctrl1  = dtc_hit(cpu_wr_i, cpu_addr_i, `DTC_ADDR_CTRL1);
   assign wr_irq0   = dtc_hit(cpu_wr_i, cpu_addr_i, `DTC_ADDR_IRQ0);
   assign wr_irq1   = dtc_hit(cpu_wr_i, cpu_addr_i, `DTC_ADDR_IRQ1);
   assign rd_count0 = dtc_hit(cpu_rd_i, cpu_addr_i, `DTC_ADDR_COUNT0);
   assign rd_count1 = dtc_hit(cpu_rd_i, cpu_addr_i, `DTC_ADDR_COUNT1);

   ////////////////////////////////////////////////////////////////////////////////
   // Control registers.

   // run clears only by write or measurement end.
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         control_reg_ctr0 <= dtc_ctrl_t'(`DTC_RST_CTRL);
      end else if (wr_ctrl0) begin
         control_reg_ctr0 <= dtc_ctrl_from_byte(cpu_wdata_i);
      end else if (stat_ctr0.pw_done) begin
         control_reg_ctr0.run <= 1'b0;
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         timer1_control <= dtc_ctrl_t'(`DTC_RST_CTRL);
      end else if (wr_ctrl1) begin
         timer1_control <= dtc_ctrl_from_byte(cpu_wdata_i);
      end else if (stat_ctr1.pw_done) begin
         timer1_control.run <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt control bytes; an overflow in the cycle of a write still sets its flag.

   always_comb begin
      next_irq_first  = wr_irq0 ? (cpu_wdata_i & `DTC_IRQ0_MASK) : irq_ctrl_first;
      next_irq_second = wr_irq1 ? (cpu_wdata_i & `DTC_IRQ1_MASK) : irq_ctrl_second;
      if (stat_ctr0.ovf) begin
         next_irq_first[`DTC_BIT_FLAG_CTR0] = 1'b1;
      end
      if (stat_ctr1.ovf) begin
         next_irq_second[`DTC_BIT_FLAG_CTR1] = 1'b1;
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         irq_ctrl_first  <= `DTC_RST_IRQ;
         irq_ctrl_second <= `DTC_RST_IRQ;
      end else begin
         irq_ctrl_first  <= next_irq_first;
         irq_ctrl_second <= next_irq_second;
      end
   end

   assign irq_req_ctr0_o = irq_ctrl_first[`DTC_BIT_MASTER_EN] & irq_ctrl_first[`DTC_BIT_EN_CTR0]
                           & irq_ctrl_first[`DTC_BIT_FLAG_CTR0];
   assign irq_req_ctr1_o = irq_ctrl_first[`DTC_BIT_MASTER_EN] & irq_ctrl_second[`DTC_BIT_EN_CTR1]
                           & irq_ctrl_second[`DTC_BIT_FLAG_CTR1];

   assign wake_req_o = stat_ctr0.ovf | stat_ctr1.ovf;

   ////////////////////////////////////////////////////////////////////////////////
   // Clock sources.

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         div4_cnt <= 2'h0;
      end else begin
         div4_cnt <= div4_cnt + 2'h1;
      end
   end

   assign div4_tick = (div4_cnt == `DTC_DIV4_LAST);
   assign tick_ctr0 = control_reg_ctr0.src_sel ? (OPT_CTR0_DIV4 ? div4_tick : 1'b1) : rtc_tick_i;

   always_comb begin
      case (OPT_CTR1_SRC)
         `DTC_SRC1_OVF0:   opt_tick_ctr1 = stat_ctr0.ovf;
         `DTC_SRC1_SYSCLK: opt_tick_ctr1 = 1'b1;
         `DTC_SRC1_TBASE:  opt_tick_ctr1 = tbase_tick_i;
         default:          opt_tick_ctr1 = 1'b0;
      endcase
   end

   assign tick_ctr1 = timer1_control.src_sel ? div4_tick : opt_tick_ctr1;

   ////////////////////////////////////////////////////////////////////////////////
   // Counters and divider pin.

   dtc_counter u_ctr0 (
      .clock_i  (clock_i),
      .arst_n_i (arst_n_i),
      .ctrl_i   (control_reg_ctr0),
      .tick_i   (tick_ctr0),
      .evt_i    (event_pin0_i),
      .load_i   (wr_count0),
      .wdata_i  (cpu_wdata_i),
      .hold_i   (rd_count0),
      .stat_o   (stat_ctr0)
   );

   dtc_counter u_ctr1 (
      .clock_i  (clock_i),
      .arst_n_i (arst_n_i),
      .ctrl_i   (timer1_control),
      .tick_i   (tick_ctr1),
      .evt_i    (event_pin1_i),
      .load_i   (wr_count1),
      .wdata_i  (cpu_wdata_i),
      .hold_i   (rd_count1),
      .stat_o   (stat_ctr1)
   );

   assign pfd_ovf = OPT_PFD_CTR1 ? stat_ctr1.ovf : stat_ctr0.ovf;

   dtc_divider_pin u_pin (
      .clock_i    (clock_i),
      .arst_n_i   (arst_n_i),
      .ovf_i      (pfd_ovf),
      .latch_i    (divider_latch_i),
      .pin_o      (shared_divider_pin_o),
      .pin_oe_n_o (shared_divider_pin_oe_n_o)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Read data.

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cpu_rdata_o <= `DTC_RST_READ;
      end else if (cpu_rd_i) begin
         case (cpu_addr_i)
            `DTC_ADDR_COUNT0: cpu_rdata_o <= stat_ctr0.count;
            `DTC_ADDR_CTRL0:  cpu_rdata_o <= control_reg_ctr0;
            `DTC_ADDR_COUNT1: cpu_rdata_o <= stat_ctr1.count;
            `DTC_ADDR_CTRL1:  cpu_rdata_o <= timer1_control;
            `DTC_ADDR_IRQ0:   cpu_rdata_o <= irq_ctrl_first;
            `DTC_ADDR_IRQ1:   cpu_rdata_o <= irq_ctrl_second;
            default:          cpu_rdata_o <= `DTC_RST_READ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.

   a_wrap_reload: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      stat_ctr0.ovf && !$past(wr_count0) |-> stat_ctr0.count == $past(u_ctr0.preload))
      else $error("counter zero did not reload on overflow");

   a_flag_set: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      stat_ctr0.ovf |=> irq_ctrl_first[`DTC_BIT_FLAG_CTR0])
      else $error("overflow flag of counter zero not set");

   a_count_step: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      control_reg_ctr0.run && control_reg_ctr0.mode == DTC_MODE_TIMER && tick_ctr0 && !rd_count0
      && !wr_ctrl0 && stat_ctr0.count != `DTC_COUNT_TOP |=> stat_ctr0.count == $past(stat_ctr0.count) + 8'h01)
      else $error("timer mode did not step by one");

   a_stop_hold: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      !control_reg_ctr0.run && !wr_count0 |=> stat_ctr0.count == $past(stat_ctr0.count))
      else $error("stopped counter zero changed");

   a_stop_load: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      wr_count0 && !control_reg_ctr0.run |=> stat_ctr0.count == $past(cpu_wdata_i))
      else $error("stopped write did not load counter");

   a_run_keep: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      wr_count0 && control_reg_ctr0.run && control_reg_ctr0.mode == DTC_MODE_TIMER && tick_ctr0 && !wr_ctrl0
      && !rd_count0 && stat_ctr0.count != `DTC_COUNT_TOP
      |=> stat_ctr0.count == $past(stat_ctr0.count) + 8'h01 && u_ctr0.preload == $past(cpu_wdata_i))
      else $error("running write disturbed counter zero");

   a_read_block: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      rd_count1 && !wr_count1 |=> stat_ctr1.count == $past(stat_ctr1.count))
      else $error("counter one moved during a read");

   a_pw_clear: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      stat_ctr0.pw_done && !wr_ctrl0 |=> !control_reg_ctr0.run ##1 !control_reg_ctr0.run || $past(wr_ctrl0))
      else $error("measurement end did not clear run");

   a_run_sticky: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      control_reg_ctr0.run && control_reg_ctr0.mode != DTC_MODE_PULSE && !wr_ctrl0 |=> control_reg_ctr0.run)
      else $error("run bit cleared by itself");

   a_irq_gate: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      !irq_ctrl_second[`DTC_BIT_EN_CTR1] |-> !irq_req_ctr1_o)
      else $error("disabled interrupt still requested");

   a_wake_src: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      $rose(stat_ctr1.ovf) |-> wake_req_o)
      else $error("overflow gave no wake request");

   a_pin_latch: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      divider_latch_i [*2] |-> !shared_divider_pin_o)
      else $error("divider pin not low with latch set");

   a_pfd_toggle: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      pfd_ovf && !divider_latch_i ##1 !divider_latch_i |=> shared_divider_pin_o != $past(shared_divider_pin_o))
      else $error("divider pin did not toggle on overflow");

   a_read_hold0: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      rd_count0 && !wr_count0 |=> stat_ctr0.count == $past(stat_ctr0.count))
      else $error("counter zero moved during a read");

   a_event_step: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      timer1_control.run && timer1_control.mode == DTC_MODE_EVENT && !rd_count1 && !wr_ctrl1
      && (timer1_control.edge_sel ? $fell(event_pin1_i) : $rose(event_pin1_i))
      && stat_ctr1.count != `DTC_COUNT_TOP |=> stat_ctr1.count == $past(stat_ctr1.count) + 8'h01)
      else $error("active event edge did not step counter one");

   a_event_skip: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      timer1_control.mode == DTC_MODE_EVENT && !wr_count1
      && (timer1_control.edge_sel ? !$fell(event_pin1_i) : !$rose(event_pin1_i)) |=> $stable(stat_ctr1.count))
      else $error("counter one moved without its active edge");

   a_mode_none: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      timer1_control.mode == DTC_MODE_NONE && !wr_count1 |=> $stable(stat_ctr1.count))
      else $error("unused mode advanced counter one");

   a_cascade: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      OPT_CTR1_SRC == `DTC_SRC1_OVF0 && timer1_control.run && timer1_control.mode == DTC_MODE_TIMER
      && !timer1_control.src_sel && stat_ctr0.ovf && !rd_count1 && !wr_ctrl1
      && stat_ctr1.count != `DTC_COUNT_TOP |=> stat_ctr1.count == $past(stat_ctr1.count) + 8'h01)
      else $error("counter one missed a counter zero overflow");

   a_pw_static: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      u_ctr0.pw_state == DTC_PW_WAIT && $stable(event_pin0_i) |=> u_ctr0.pw_state != DTC_PW_MEAS)
      else $error("static level started a measurement");

   a_pw_keep: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      u_ctr0.pw_state == DTC_PW_DONE && !wr_count0 |=> $stable(stat_ctr0.count))
      else $error("finished measurement lost its count");

   a_pfd_src: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      !OPT_PFD_CTR1 && !stat_ctr0.ovf |=> $stable(u_pin.freq_divider_out))
      else $error("divider toggled without its counter overflow");

   a_irq_gate0: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      !irq_ctrl_first[`DTC_BIT_EN_CTR0] |-> !irq_req_ctr0_o)
      else $error("disabled counter zero interrupt requested");

   c_overflow: cover property (@(posedge clock_i) disable iff (!arst_n_i) stat_ctr0.ovf ##1 irq_req_ctr0_o);
   c_cascade: cover property (@(posedge clock_i) disable iff (!arst_n_i) stat_ctr0.ovf && stat_ctr1.ovf);
   c_pulse_done: cover property (@(posedge clock_i) disable iff (!arst_n_i) stat_ctr1.pw_done);
   c_pin_high: cover property (@(posedge clock_i) disable iff (!arst_n_i) $rose(shared_divider_pin_o));
   c_event_step: cover property (@(posedge clock_i) disable iff (!arst_n_i)
      timer1_control.mode == DTC_MODE_EVENT ##1 $changed(stat_ctr1.count));
endmodule

// File: verif/dtc_event_src.sv
// Far-side model of the two external event pins of the timer block.
// Assumes the bench calls its tasks and that the pins change only at a falling clock edge.
`timescale 1ns/1ps
module dtc_event_src (
   input  wire logic clock_i,
   output logic      pin0_o,
   output logic      pin1_o
);
   initial begin
      pin0_o = 1'b0;
      pin1_o = 1'b0;
   end
   task automatic level(input int idx, input logic v);
      @(negedge clock_i);
      if (idx == 0) begin
         pin0_o = v;
      end else begin
         pin1_o = v;
      end
   endtask
   // Holds the pin high for w whole cycles.
   task automatic pulse(input int idx, input int w);
      level(idx, 1'b1);
      repeat (w - 1) @(negedge clock_i);
      level(idx, 1'b0);
   endtask
endmodule

// File: verif/dtc_timer_top_tb.sv
// Self-checking bench of the dual timer block: register bus, event pins and divider pin.
// Assumes the event pin model and the design files compiled before it.
`timescale 1ns/1ps
`include "dtc_regs.svh"
module dtc_timer_top_tb
   import dtc_pkg::*;
;
   logic        clock_i, arst_n_i, cpu_wr_i, cpu_rd_i, rtc_tick_i, tbase_tick_i;
   logic [7:0]  cpu_addr_i, cpu_wdata_i, cpu_rdata_o, n, c1, v, exp_c, last_rd;
   logic        ev0, ev1, divider_latch_i, irq0, irq1, wake, pin, pin_oe_n;
   logic        div_on, rd_q, wake_q, wake_q2, pin_q, latch_q;
   logic [15:0] exp_q[$];
   logic [15:0] e;
   int          errors, checks, cyc, wakes, lat_n, w;
   int          last_w = -1;
   int          seed = 22;
   logic [7:0]  rst_addr [5] = '{8'h0E, 8'h11, 8'h0B, 8'h1E, 8'h3F};
   logic [7:0]  ev_ctl [4]   = '{8'h58, 8'h50, 8'h10, 8'h48};
   logic [1:0]  ev_inc [4]   = '{2'h1, 2'h2, 2'h0, 2'h0};

   dtc_timer_top #(.OPT_CTR0_DIV4(1'b0), .OPT_CTR1_SRC(2'h0), .OPT_PFD_CTR1(1'b0)) u_dut (
      .clock_i(clock_i), .arst_n_i(arst_n_i), .cpu_addr_i(cpu_addr_i), .cpu_wdata_i(cpu_wdata_i),
      .cpu_wr_i(cpu_wr_i), .cpu_rd_i(cpu_rd_i), .cpu_rdata_o(cpu_rdata_o), .rtc_tick_i(rtc_tick_i),
      .tbase_tick_i(tbase_tick_i), .event_pin0_i(ev0), .event_pin1_i(ev1),
      .divider_latch_i(divider_latch_i), .irq_req_ctr0_o(irq0), .irq_req_ctr1_o(irq1),
      .wake_req_o(wake), .shared_divider_pin_o(pin), .shared_divider_pin_oe_n_o(pin_oe_n));
   dtc_event_src u_src (.clock_i(clock_i), .pin0_o(ev0), .pin1_o(ev1));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check_eq(input logic [7:0] seen, input logic [7:0] expv);
      checks++;
      if (seen !== expv) begin
         errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, expv);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock_i);
      cpu_addr_i = a;
      cpu_wdata_i = d;
      cpu_wr_i = 1'b1;
      @(negedge clock_i);
      cpu_wr_i = 1'b0;
   endtask
   // Notes the expected value and mask; the monitor compares the answer.
   task automatic rd(input logic [7:0] a, input logic [7:0] ex, input logic [7:0] m);
      @(negedge clock_i);
      cpu_addr_i = a;
      cpu_rd_i = 1'b1;
      exp_q.push_back({ex, m});
      @(negedge clock_i);
      cpu_rd_i = 1'b0;
   endtask
   task automatic wait_wake;
      for (int i = 0; i < 400 && wake !== 1'b1; i++) @(negedge clock_i);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clock_i = 1'b0;
      forever #2.5 clock_i = ~clock_i;
   end
   always @(negedge clock_i) begin
      rtc_tick_i <= 1'($random(seed));
      tbase_tick_i <= 1'($random(seed));
   end
   always @(posedge clock_i) begin
      cyc++;
      if (rd_q && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         last_rd = cpu_rdata_o;
         check_eq(cpu_rdata_o & e[7:0], e[15:8] & e[7:0]);
      end
      if (div_on && wake === 1'b1) begin
         if (last_w >= 0) check_eq(8'(cyc - last_w), 8'(16'h0100 - {8'h00, n}));
         last_w = cyc;
         wakes++;
      end
      lat_n = (divider_latch_i !== latch_q) ? 0 : lat_n + 1;
      if (lat_n >= 3 && divider_latch_i) check_eq({7'h00, pin}, 8'h00);
      else if (lat_n >= 3 && div_on) check_eq({7'h00, pin !== pin_q}, {7'h00, wake_q2});
      rd_q = cpu_rd_i;
      // The pin moves two samples after the overflow pulse: toggle flop, then pin flop.
      wake_q2 = wake_q;
      wake_q = wake;
      pin_q = pin;
      latch_q = divider_latch_i;
      if (cyc > 6000) begin
         errors++;
         report_and_stop();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {cpu_addr_i, cpu_wdata_i} = 16'h0000;
      {cpu_wr_i, cpu_rd_i, divider_latch_i, div_on} = 4'h0;
      arst_n_i = 1'b0;
      repeat (8) @(posedge clock_i);
      @(negedge clock_i);
      arst_n_i = 1'b1;
      foreach (rst_addr[i]) rd(rst_addr[i], 8'h00, 8'hFF);
      wr(`DTC_ADDR_IRQ1, 8'hFF);
      rd(`DTC_ADDR_IRQ1, 8'h11, 8'hFF);
      wr(`DTC_ADDR_IRQ1, 8'h00);
      check_eq({7'h00, pin_oe_n}, 8'h00);
      wr(`DTC_ADDR_CTRL0, 8'h10);
      wr(`DTC_ADDR_CTRL0, 8'h00);
      n = 8'($random(seed));
      wr(`DTC_ADDR_COUNT0, n);
      rd(`DTC_ADDR_COUNT0, n, 8'hFF);
      wr(`DTC_ADDR_COUNT0, 8'h80);
      wr(`DTC_ADDR_IRQ0, 8'h09);
      wr(`DTC_ADDR_CTRL0, 8'hB0);
      wr(`DTC_ADDR_COUNT0, 8'hA0);
      rd(`DTC_ADDR_COUNT0, 8'h80, 8'hF0);
      wait_wake();
      rd(`DTC_ADDR_COUNT0, 8'hA0, 8'hF0);
      rd(`DTC_ADDR_IRQ0, 8'h49, 8'hFF);
      check_eq({7'h00, irq0}, 8'h01);
      rd(`DTC_ADDR_CTRL0, 8'hB0, 8'hFF);
      wr(`DTC_ADDR_IRQ0, 8'h41);
      check_eq({7'h00, irq0}, 8'h00);
      wr(`DTC_ADDR_IRQ0, 8'h00);
      wr(`DTC_ADDR_CTRL0, 8'h00);
      c1 = 8'($random(seed)) & 8'h3F;
      wr(`DTC_ADDR_COUNT1, c1);
      wr(`DTC_ADDR_CTRL1, 8'h90);
      n = 8'hF0 | (8'($random(seed)) & 8'h0E);
      wr(`DTC_ADDR_COUNT0, n);
      div_on = 1'b1;
      wr(`DTC_ADDR_CTRL0, 8'hB0);
      repeat (80) @(negedge clock_i);
      divider_latch_i = 1'b1;
      repeat (20) @(negedge clock_i);
      divider_latch_i = 1'b0;
      repeat (30) @(negedge clock_i);
      wr(`DTC_ADDR_CTRL0, 8'h00);
      repeat (20) @(negedge clock_i);
      div_on = 1'b0;
      rd(`DTC_ADDR_COUNT1, 8'(c1 + wakes), 8'hFF);
      wr(`DTC_ADDR_CTRL1, 8'h00);
      exp_c = 8'h10;
      wr(`DTC_ADDR_COUNT1, exp_c);
      foreach (ev_ctl[i]) begin
         wr(`DTC_ADDR_CTRL1, ev_ctl[i]);
         u_src.level(1, 1'b1);
         exp_c = exp_c + 8'(ev_inc[i][1]);
         rd(`DTC_ADDR_COUNT1, exp_c, 8'hFF);
         u_src.level(1, 1'b0);
         exp_c = exp_c + 8'(ev_inc[i][0]);
         rd(`DTC_ADDR_COUNT1, exp_c, 8'hFF);
      end
      wr(`DTC_ADDR_COUNT0, 8'h00);
      u_src.level(0, 1'b1);
      wr(`DTC_ADDR_CTRL0, 8'hF8);
      repeat (10) @(negedge clock_i);
      rd(`DTC_ADDR_COUNT0, 8'h00, 8'hFF);
      u_src.level(0, 1'b0);
      w = 20 + ($random(seed) & 7);
      u_src.pulse(0, w);
      repeat (6) @(negedge clock_i);
      rd(`DTC_ADDR_CTRL0, 8'hE8, 8'hFF);
      rd(`DTC_ADDR_COUNT0, 8'h00, 8'h00);
      @(negedge clock_i);
      v = last_rd;
      check_eq({7'h00, v >= w - 2 && v <= w + 2}, 8'h01);
      u_src.pulse(0, 5);
      repeat (4) @(negedge clock_i);
      rd(`DTC_ADDR_COUNT0, v, 8'hFF);
      repeat (3) @(negedge clock_i);
      report_and_stop();
   end
endmodule
